// file: hw/smdc_pkg.sv
// Package with constants, types and state layouts of the slot-matched data capture block.
package smdc_pkg;

   // Clock rate and timing figures.
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CLEAR_DELAY_NS = 2000;
   localparam int READY_PULSE_NS = 10000;
   localparam int CLEAR_DELAY_CYC = (CLEAR_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READY_PULSE_CYC = (READY_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Widths.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 40;
   localparam int FIFO_DEPTH = 32;
   localparam int DLY_W = 8;
   localparam int RDY_W = 11;

   // Slot counter moduli and the common reset value.
   localparam logic [4:0] A_TOP = 5'h1E;
   localparam logic [3:0] B_TOP = 4'hA;
   localparam logic [1:0] C_TOP = 2'h3;
   localparam logic [4:0] A_INIT = 5'h01;
   localparam logic [3:0] B_INIT = 4'h1;
   localparam logic [1:0] C_INIT = 2'h1;

   // Address field positions (bit 1 of the address is index 0).
   localparam int WAVE_BIT = 0;
   localparam int A_LSB = 1;
   localparam int A_MSB = 5;
   localparam int B_LSB = 6;
   localparam int B_MSB = 9;
   localparam int C_LSB = 10;
   localparam int C_MSB = 11;

   // Capture sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_LOAD
   } smdc_fsm_t;

   // Slot counter array.
   typedef struct packed {
      logic [4:0] a;
      logic [3:0] b;
      logic [1:0] c;
   } smdc_slots_t;

   // Whole state of the capture logic.
   typedef struct packed {
      smdc_slots_t             slots;
      logic                    aligned;
      logic                    in_sync;
      logic                    gate_prev;
      smdc_fsm_t               fsm;
      logic [DLY_W-1:0]        dly;
      logic [RDY_W-1:0]        rdy_cnt;
      logic                    ready;
      logic [DATA_W-1:0]       hold;
   } smdc_state_t;

endpackage

// file: hw/smdc_capture.sv
// Slot-matched data capture: slot counters, address match, holding register and output FIFO.
//
// Function
// R1: Address bits 11 and 12 are compared with the two bits of the divide-by-three counter.
// R2: The third-group qualifier is true on that match or when address bits 11 and 12 are zero.
// R3: The requester zeroes address groups to ignore the divide-by-ten or divide-by-three counter.
// R4: The data-entry gate ANDs the first-group match, both qualifiers, sync and request.
// R5: Counter synchronisation is checked and every transfer is blocked while it is false; the code blocks only the start, not a load after ST_WAIT.
// R6: The requester holds its request true and the gate uses that request level as a term.
// R7: With sync and request present the next true comparison clears the holding register.
// R8: After a delay of a few microseconds the data inputs are loaded into the holding register.
// R9: The load pulse starts a one-shot that drives data ready back to the requester.
// R10: The one-shot pulse has a fixed length in clocks and restarts only on a new load.
// R11: The counters recycle after 30, 10 and 3 counts and the common reset sets them to one.
// R12: The divide-by-thirty counter steps on each sync pulse and its recycle steps the others.
// R13: Address bit 1 matches waveform b and address bits 2 to 6 match the divide-by-thirty counter.
// R14: The second-group qualifier is true when address bits 7 to 10 match the decade or are zero.
`timescale 1ns/1ps

module smdc_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   // Filling side.
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Draining side.
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0]  wp;
      logic [PW-1:0]  rp;
      logic [PW:0]    cnt;
      logic           ov;
      logic [WIDTH-1:0] od;
   } smdc_fifo_state_t;

   smdc_fifo_state_t st_reg;
   smdc_fifo_state_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // A word is taken when there is room; a word moves to the output stage when it is free.
   assign push = i_in_valid && (st_reg.cnt != (PW+1)'(DEPTH));
   assign pop = (st_reg.cnt != '0) && (!st_reg.ov || i_out_ready);
   assign o_in_ready = (st_reg.cnt != (PW+1)'(DEPTH));
   assign o_out_valid = st_reg.ov;
   assign o_out_data = st_reg.od;

   // Next pointer, count and output stage values.
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
         st_next.ov = 1'b1;
         st_next.od = mem[st_reg.rp];
      end else if (i_out_ready) begin
         st_next.ov = 1'b0;
      end
      st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   // State register.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage array, written without reset.
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[st_reg.wp] <= i_in_data;
      end
   end
endmodule

module smdc_capture (
   // Clock and reset.
   input  wire logic                         i_mclk,
   input  wire logic                         i_rst_n,
   // Telemetry timing.
   input  wire logic                         i_sync_pulse,
   input  wire logic                         i_frame_sync,
   input  wire logic                         i_waveform_b,
   // Computer data adapter request side.
   input  wire logic [smdc_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic                         i_data_req,
   input  wire logic [smdc_pkg::DATA_W-1:0]  i_data,
   output logic                              o_data_ready,
   // Holding register and status.
   output logic [smdc_pkg::DATA_W-1:0]       o_hold_data,
   output logic                              o_in_sync,
   // Captured word stream.
   output logic                              o_word_valid,
   output logic [smdc_pkg::DATA_W-1:0]       o_word_data,
   input  wire logic                         i_word_ready
);
   smdc_pkg::smdc_state_t st_reg;
   smdc_pkg::smdc_state_t st_next;
   logic                  a_wrap;
   logic                  all_top;
   logic                  match_a;
   logic                  match_c;
   logic                  second_group_qualifier;
   logic                  third_group_qualifier;
   logic                  data_entry_gate;
   logic                  fire;
   logic                  load;
   logic                  fifo_in_ready;

   // Counter recycle and frame-boundary position.
   assign a_wrap = i_sync_pulse && (st_reg.slots.a == smdc_pkg::A_TOP);
   assign all_top = (st_reg.slots.a == smdc_pkg::A_TOP) && (st_reg.slots.b == smdc_pkg::B_TOP)
                    && (st_reg.slots.c == smdc_pkg::C_TOP);

   // Address comparators and zero detectors.
   assign match_a = (i_addr[smdc_pkg::WAVE_BIT] == i_waveform_b)
                    && (i_addr[smdc_pkg::A_MSB:smdc_pkg::A_LSB] == st_reg.slots.a); // [R13]
   assign second_group_qualifier = (i_addr[smdc_pkg::B_MSB:smdc_pkg::B_LSB] == st_reg.slots.b)
                    || (i_addr[smdc_pkg::B_MSB:smdc_pkg::B_LSB] == '0); // [R14] [R3]
   assign match_c = (i_addr[smdc_pkg::C_MSB:smdc_pkg::C_LSB] == st_reg.slots.c); // [R1]
   assign third_group_qualifier = match_c
                    || (i_addr[smdc_pkg::C_MSB:smdc_pkg::C_LSB] == '0); // [R2] [R3]

   // Data-entry gate: all comparisons, sync and the held request level.
   assign data_entry_gate = match_a && second_group_qualifier && third_group_qualifier
                            && st_reg.in_sync && i_data_req; // [R4] [R5] [R6]
   assign fire = data_entry_gate && !st_reg.gate_prev && (st_reg.fsm == smdc_pkg::ST_IDLE);
   assign load = (st_reg.fsm == smdc_pkg::ST_LOAD) && fifo_in_ready;

   // Next state of counters, sync check, sequencer and one-shot.
   always_comb begin
      st_next = st_reg;
      st_next.gate_prev = data_entry_gate;
      // Slot counters.
      if (i_frame_sync) begin
         st_next.slots.a = smdc_pkg::A_INIT; // [R11]
         st_next.slots.b = smdc_pkg::B_INIT;
         st_next.slots.c = smdc_pkg::C_INIT;
      end else if (i_sync_pulse) begin
         st_next.slots.a = a_wrap ? smdc_pkg::A_INIT : st_reg.slots.a + 5'h01; // [R12] [R11]
         if (a_wrap) begin
            st_next.slots.b = (st_reg.slots.b == smdc_pkg::B_TOP) ? smdc_pkg::B_INIT
                              : st_reg.slots.b + 4'h1; // [R12]
            st_next.slots.c = (st_reg.slots.c == smdc_pkg::C_TOP) ? smdc_pkg::C_INIT
                              : st_reg.slots.c + 2'h1;
         end
      end
      // Sync check: first frame aligns, later frames must find the counters at their top.
      if (i_frame_sync) begin
         st_next.aligned = 1'b1;
         st_next.in_sync = !st_reg.aligned || all_top; // [R5]
      end
      // Capture sequencer.
      case (st_reg.fsm)
         smdc_pkg::ST_IDLE: begin
            if (fire) begin
               st_next.hold = '0; // [R7]
               st_next.dly = smdc_pkg::DLY_W'(smdc_pkg::CLEAR_DELAY_CYC - 1);
               st_next.fsm = smdc_pkg::ST_WAIT;
            end
         end
         smdc_pkg::ST_WAIT: begin
            if (st_reg.dly == '0) begin
               st_next.fsm = smdc_pkg::ST_LOAD; // [R8]
            end else begin
               st_next.dly = st_reg.dly - 1'b1;
            end
         end
         smdc_pkg::ST_LOAD: begin
            if (load) begin
               st_next.hold = i_data; // [R8]
               st_next.fsm = smdc_pkg::ST_IDLE;
            end
         end
         default: begin
            st_next.fsm = smdc_pkg::ST_IDLE;
         end
      endcase
      // Data-ready one-shot, restarted only by a load.
      if (load) begin
         st_next.ready = 1'b1; // [R9] [R10]
         st_next.rdy_cnt = smdc_pkg::RDY_W'(smdc_pkg::READY_PULSE_CYC - 1);
      end else if (st_reg.rdy_cnt != '0) begin
         st_next.rdy_cnt = st_reg.rdy_cnt - 1'b1;
      end else begin
         st_next.ready = 1'b0; // [R10]
      end
   end

   // State register.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_reg <= '{slots: '{a: smdc_pkg::A_INIT, b: smdc_pkg::B_INIT, c: smdc_pkg::C_INIT},
                    fsm: smdc_pkg::ST_IDLE, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // Registered outputs.
   assign o_data_ready = st_reg.ready;
   assign o_hold_data = st_reg.hold;
   assign o_in_sync = st_reg.in_sync;

   // Output FIFO fed with each loaded word; a full FIFO stalls the load.
   smdc_fifo #(
      .WIDTH (smdc_pkg::DATA_W),
      .DEPTH (smdc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (load),
      .i_in_data   (i_data),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (o_word_valid),
      .o_out_data  (o_word_data),
      .i_out_ready (i_word_ready)
   );

   // Assertions and covers.
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // Address comparators and qualifiers, checked against the counters and the zero fields.
   a_third_match: assert property ( // [R1]
      match_c == ((i_addr[smdc_pkg::C_LSB] == st_reg.slots.c[0])
                  && (i_addr[smdc_pkg::C_MSB] == st_reg.slots.c[1])))
      else $error("Third-group match wrong.");
   a_third_qual: assert property ((i_addr[smdc_pkg::C_MSB:smdc_pkg::C_LSB] == '0) // [R2]
      |-> third_group_qualifier)
      else $error("Zero third group not qualified.");
   a_first_match: assert property (match_a |-> // [R13]
      (i_addr[smdc_pkg::WAVE_BIT] == i_waveform_b)
      && (i_addr[smdc_pkg::A_MSB:smdc_pkg::A_LSB] == st_reg.slots.a))
      else $error("First-group match wrong.");
   a_second_qual: assert property ( // [R14]
      (i_addr[smdc_pkg::B_MSB:smdc_pkg::B_LSB] == st_reg.slots.b)
      || (i_addr[smdc_pkg::B_MSB:smdc_pkg::B_LSB] == '0) |-> second_group_qualifier)
      else $error("Second-group match missed.");

   // The sequencer leaves idle only when every gate term held in the cycle before.
   a_gate_terms: assert property (st_reg.fsm == smdc_pkg::ST_IDLE // [R4]
      ##1 st_reg.fsm == smdc_pkg::ST_WAIT |-> $past(match_a && second_group_qualifier
      && third_group_qualifier && i_data_req && st_reg.in_sync))
      else $error("Transfer started without full gate.");
   a_sync_block: assert property (!st_reg.in_sync && st_reg.fsm == smdc_pkg::ST_IDLE // [R5]
      |=> st_reg.fsm == smdc_pkg::ST_IDLE)
      else $error("Transfer started out of sync.");
   a_req_term: assert property (!i_data_req && st_reg.fsm == smdc_pkg::ST_IDLE // [R6]
      |=> st_reg.fsm == smdc_pkg::ST_IDLE)
      else $error("Transfer started without request.");

   // Clear, delay and load of the holding register.
   a_clear_hold: assert property (fire |=> st_reg.hold == '0) // [R7]
      else $error("Holding register not cleared.");
   a_load_delay: assert property (fire |=> (st_reg.fsm == smdc_pkg::ST_WAIT) [*8]) // [R8]
      else $error("Load came too early after clear.");
   a_load_late: assert property (fire |-> ##250 st_reg.fsm == smdc_pkg::ST_WAIT // [R8]
      ##1 st_reg.fsm == smdc_pkg::ST_LOAD)
      else $error("Load state not reached after the clear delay.");
   a_load_data: assert property (load |=> st_reg.hold == $past(i_data)) // [R8]
      else $error("Holding register not loaded.");

   // Data-ready one-shot.
   a_ready_start: assert property (load |=> o_data_ready) // [R9]
      else $error("Data ready not raised by load.");
   a_ready_len: assert property ($rose(o_data_ready) |-> o_data_ready [*8]) // [R10]
      else $error("Data ready pulse too short.");
   a_ready_cause: assert property ($rose(o_data_ready) |-> $past(load)) // [R10]
      else $error("Data ready raised without load.");

   // Slot counters.
   a_common_reset: assert property (i_frame_sync |=> st_reg.slots.a == smdc_pkg::A_INIT // [R11]
      && st_reg.slots.b == smdc_pkg::B_INIT && st_reg.slots.c == smdc_pkg::C_INIT)
      else $error("Counters not set to one.");
   a_a_recycle: assert property (a_wrap && !i_frame_sync |=> st_reg.slots.a == smdc_pkg::A_INIT) // [R11]
      else $error("Thirty counter did not recycle.");
   a_b_recycle: assert property (a_wrap && !i_frame_sync // [R11]
      && st_reg.slots.b == smdc_pkg::B_TOP |=> st_reg.slots.b == smdc_pkg::B_INIT)
      else $error("Decade counter did not recycle.");
   a_c_recycle: assert property (a_wrap && !i_frame_sync // [R11]
      && st_reg.slots.c == smdc_pkg::C_TOP |=> st_reg.slots.c == smdc_pkg::C_INIT)
      else $error("Three counter did not recycle.");
   a_carry_step: assert property (i_sync_pulse && !a_wrap && !i_frame_sync // [R12]
      |=> st_reg.slots.b == $past(st_reg.slots.b) && st_reg.slots.c == $past(st_reg.slots.c))
      else $error("Decade or three counter stepped without carry.");

   // Main scenarios: capture, load, lost sync, stalled load and a restarted ready pulse.
   c_capture: cover property (fire ##1 st_reg.fsm == smdc_pkg::ST_WAIT);
   c_load: cover property (load);
   c_sync_lost: cover property ($fell(st_reg.in_sync));
   c_fifo_full: cover property (st_reg.fsm == smdc_pkg::ST_LOAD && !fifo_in_ready);
   c_retrigger: cover property (load && st_reg.ready);
endmodule

// file: tb/smdc_adapter_model.sv
// Behavioural model of the computer data adapter that issues addressed capture requests.
`timescale 1ns/1ps

module smdc_adapter_model (
   // Clock.
   input  wire logic                        i_mclk,
   // Request side towards the capture block.
   output logic [smdc_pkg::ADDR_W-1:0]      o_addr,
   output logic                             o_data_req,
   output logic [smdc_pkg::DATA_W-1:0]      o_data,
   // Answer seen from the capture block.
   input  wire logic                        i_data_ready,
   input  wire logic [smdc_pkg::DATA_W-1:0] i_hold_data
);
   // Lines start quiet with the request low.
   initial begin
      o_addr = 12'h000;
      o_data_req = 1'b0;
      o_data = 40'h00_0000_0000;
   end

   // Holds request, address and data until the word is loaded or the wait runs out.
   task automatic request(input logic [11:0] a, input logic [39:0] d, input int max_wait,
                          output int clr_at, output int load_at);
      int n;
      begin
         clr_at = -1;
         load_at = -1;
         n = 0;
         @(posedge i_mclk);
         #1;
         o_addr = a;
         o_data = d;
         o_data_req = 1'b1;
         while (load_at < 0 && n < max_wait) begin
            @(posedge i_mclk);
            #1;
            n++;
            if (clr_at < 0 && i_hold_data === 40'h00_0000_0000) clr_at = n;
            if (i_hold_data === d && i_data_ready === 1'b1) load_at = n;
         end
         // Released lines show the inverse so a stale word never looks valid.
         o_data_req = 1'b0;
         o_addr = ~a;
         o_data = ~d;
      end
   endtask
endmodule

// file: tb/slot_matched_data_capture_test.sv
// Self-checking testbench of the slot-matched data capture block.
`timescale 1ns/1ps

module slot_matched_data_capture_test;
   logic                         mclk;
   logic                         rst_n;
   logic                         sync_pulse;
   logic                         frame_sync;
   logic                         wave_b;
   logic                         word_ready;
   logic [smdc_pkg::ADDR_W-1:0]  addr;
   logic                         data_req;
   logic [smdc_pkg::DATA_W-1:0]  data;
   logic                         data_ready;
   logic [smdc_pkg::DATA_W-1:0]  hold_data;
   logic                         in_sync;
   logic                         word_valid;
   logic [smdc_pkg::DATA_W-1:0]  word_data;
   int                           err_count = 0;
   int                           samples_checked = 0;
   int                           cycles = 0;

   smdc_capture dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_sync_pulse(sync_pulse),
      .i_frame_sync(frame_sync), .i_waveform_b(wave_b), .i_addr(addr), .i_data_req(data_req),
      .i_data(data), .o_data_ready(data_ready), .o_hold_data(hold_data), .o_in_sync(in_sync),
      .o_word_valid(word_valid), .o_word_data(word_data), .i_word_ready(word_ready));

   smdc_adapter_model adapter (.i_mclk(mclk), .o_addr(addr), .o_data_req(data_req),
      .o_data(data), .i_data_ready(data_ready), .i_hold_data(hold_data));

   // Clock of 8 ns.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Cuts a hang short well beyond the expected run length.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         give_verdict();
      end
   end

   // Compares a seen value with the expected one and reports a mismatch.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Sends n slot pulses, or n frame pulses when frame is set.
   task automatic pulse(input int n, input bit frame);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         #1;
         sync_pulse = !frame;
         frame_sync = frame;
         @(posedge mclk);
         #1;
         sync_pulse = 1'b0;
         frame_sync = 1'b0;
      end
   endtask

   // Steps the slots, then requests one word and judges capture or refusal.
   task automatic try(input int n, input logic w, input logic [11:0] a, input logic [39:0] d,
                      input bit ok);
      int clr;
      int ld;
      begin
         pulse(n, 1'b0);
         wave_b = w;
         adapter.request(a, d, ok ? 260 : 300, clr, ld);
         check(ld, ok ? 252 : -1);
         if (ok) begin
            check(clr, 1);
            check(data_ready, 1'b1);
         end
      end
   endtask

   // No capture before the first frame sync, which then brings the block into sync.
   task automatic t_unsynced();
      check(in_sync, 1'b0);
      check(data_ready, 1'b0);
      try(0, 1'b0, 12'h002, 40'h11_1111_1111, 1'b0);
      pulse(1, 1'b1);
      check(in_sync, 1'b1);
   endtask

   // Waveform match, then a load that restarts a still-running ready pulse.
   task automatic t_timing();
      int n;
      begin
         try(0, 1'b1, 12'h003, 40'h22_2222_2222, 1'b1);
         try(0, 1'b1, 12'h002, 40'h33_3333_3333, 1'b0);
         try(0, 1'b1, 12'h003, 40'h44_4444_4444, 1'b1);
         n = 0;
         while (data_ready === 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
         end
         check(n, 1250);
      end
   endtask

   // Counter stepping and group qualifiers; counters start at one after frame sync.
   task automatic t_match();
      int np[7] = '{4, 0, 26, 0, 0, 0, 0};
      logic [11:0] ad[7] = '{12'h00A, 12'h008, 12'h882, 12'h482, 12'h0C2, 12'h082, 12'h802};
      bit ok[7] = '{1, 0, 1, 0, 0, 1, 1};
      for (int i = 0; i < 7; i++) begin
         try(np[i], 1'b0, ad[i], 40'h55_0000_0000 + i, ok[i]);
      end
   endtask

   // A misplaced frame sync drops sync; a full 900-slot frame restores it.
   task automatic t_resync();
      pulse(1, 1'b1);
      check(in_sync, 1'b0);
      try(0, 1'b0, 12'h002, 40'h66_6666_6666, 1'b0);
      pulse(899, 1'b0);
      pulse(1, 1'b1);
      check(in_sync, 1'b1);
   endtask

   // Fills the stalled stream until the load waits, then drains it in order.
   task automatic t_fifo();
      int clr;
      int ld;
      int k;
      begin
         word_ready = 1'b0;
         for (int i = 0; i < 33; i++) begin
            try(0, 1'b0, 12'h002, 40'hC0_0000_0000 + i, 1'b1);
         end
         fork
            adapter.request(12'h002, 40'hC0_0000_0021, 1500, clr, ld);
            begin
               repeat (400) @(posedge mclk);
               #1;
               check(hold_data, 40'h00_0000_0000);
               word_ready = 1'b1;
               for (int i = 0; i < 34; i++) begin
                  k = 0;
                  while (word_valid !== 1'b1 && k < 300) begin
                     @(posedge mclk);
                     #1;
                     k++;
                  end
                  check(word_data, 40'hC0_0000_0000 + i);
                  @(posedge mclk);
                  #1;
               end
            end
         join
         check(ld > 400, 1'b1);
         check(word_valid, 1'b0);
      end
   endtask

   // Reset, then the scenarios in order.
   initial begin
      rst_n = 1'b0;
      sync_pulse = 1'b0;
      frame_sync = 1'b0;
      wave_b = 1'b0;
      word_ready = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      check(hold_data, 40'h00_0000_0000);
      check(word_valid, 1'b0);
      t_unsynced();
      t_timing();
      t_match();
      t_resync();
      t_fifo();
      give_verdict();
   end
endmodule
